//--- tb/lock_serr_ctrl_tb_top.sv
// Bench for lock forwarding and system error control
module lock_serr_ctrl_tb_top;
    import lock_serr_pkg::*;
    timeunit 1ns;
    timeprecision 1ns;
    logic i_clk, i_rstn, i_avs_read, i_avs_write, o_avs_waitrequest;
    logic [3:0] i_avs_address, i_avs_byteenable;
    logic [31:0] i_avs_writedata, o_avs_readdata, rd_q;
    logic [NUM_EV-1:0] i_event;
    logic i_event_locked_pw, i_secondary_system_error_in_n, o_primary_system_error_out_oe_n;
    lock_req_t i_req;
    lock_rsp_t o_rsp, rsp_q;
    logic i_pri_lock_n, i_pri_frame_n, i_queue_older_empty, i_sec_idle, i_sec_lock_in_n;
    logic i_sec_data_done, i_sec_retry, i_sec_abort, i_repeat_match, i_pw_done_unlock;
    logic o_queue_block, o_issue_locked, o_sec_lock_out_oe_n, o_pri_lock_held, p_other;
    logic [1:0] p_mode, p_delay;
    int n_fail, samples_checked;
    cmd_t bad_cmd [4] = '{CMD_MEM_WRITE, CMD_IO, CMD_CFG0, CMD_CFG1};
    logic [3:0] regs [5] = '{ADDR_CTRL, ADDR_MASK, ADDR_EVT, ADDR_STAT, 4'h2};

    lock_serr_ctrl lock_serr_ctrl_i (.*);
    lock_serr_partner lock_serr_partner_i (.i_clk(i_clk), .i_rstn(i_rstn),
        .i_issue(o_issue_locked), .i_mode(p_mode), .i_delay(p_delay), .i_other_lock(p_other),
        .i_lock_oe_n(o_sec_lock_out_oe_n), .o_sec_idle(i_sec_idle), .o_lock_n(i_sec_lock_in_n),
        .o_data_done(i_sec_data_done), .o_retry(i_sec_retry), .o_abort(i_sec_abort));

    // 50 ns clock
    initial begin
        i_clk = 1'b0;
        forever #25 i_clk = ~i_clk;
    end

    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        samples_checked++;
        if (seen !== exp) begin
            n_fail++;
            $display("[ERR] t=%0t seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic conclude();
        $display("checks %0d fails %0d", samples_checked, n_fail);
        if (n_fail == 0 && samples_checked > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask
    task automatic tend(input string s);
        $display("%s done, fails %0d", s, n_fail);
    endtask
    // Avalon access held until waitrequest is seen low at an edge
    task automatic bus(input logic w, input logic [3:0] a, input logic [31:0] d);
        @(posedge i_clk);
        i_avs_address <= a;
        i_avs_writedata <= d;
        i_avs_write <= w;
        i_avs_read <= !w;
        do @(posedge i_clk); while (o_avs_waitrequest !== 1'b0);
        rd_q = o_avs_readdata;
        i_avs_write <= 1'b0;
        i_avs_read <= 1'b0;
    endtask
    task automatic wr(input logic [3:0] a, input logic [31:0] d);
        bus(1'b1, a, d);
    endtask
    task automatic rdc(input logic [3:0] a, input logic [31:0] e);
        bus(1'b0, a, 32'h0);
        chk(rd_q, e);
    endtask
    task automatic clr();
        wr(ADDR_EVT, 32'h7f);
        wr(ADDR_STAT, 32'h13);
    endtask
    // One-cycle cause; drive due at the edge that samples it, one cycle after it is applied
    task automatic ev(input logic [NUM_EV-1:0] b, input logic lpw, input logic drv);
        @(posedge i_clk);
        i_event <= b;
        i_event_locked_pw <= lpw;
        @(posedge i_clk);
        i_event <= '0;
        i_event_locked_pw <= 1'b0;
        #1 chk(o_primary_system_error_out_oe_n, !drv);
    endtask
    // frame in address phase, lock asserted one clock later
    task automatic req(input logic lk, input logic dn, input logic fi, input cmd_t c);
        @(posedge i_clk);
        i_req <= '{1'b1, lk, dn, fi, c};
        i_pri_frame_n <= 1'b0;
        @(posedge i_clk);
        i_req.valid <= 1'b0;
        i_pri_frame_n <= 1'b1;
        if (lk) i_pri_lock_n <= 1'b0;
        #1 rsp_q = o_rsp;
    endtask
    // Initiator drops lock, bus idle
    task automatic rel();
        @(posedge i_clk);
        i_pri_lock_n <= 1'b1;
        repeat (2) @(posedge i_clk);
        #1;
    endtask
    // Poll until target lock shows
    task automatic waitlock();
        for (int k = 0; k < 8; k++) begin
            bus(1'b0, ADDR_STAT, 32'h0);
            if (rd_q[ST_LOCK_TGT] === 1'b1) break;
        end
        chk(rd_q[ST_LOCK_TGT], 1'b1);
    endtask

    initial begin
        i_rstn = 1'b0;
        i_avs_address = 4'h0;
        i_avs_read = 1'b0;
        i_avs_write = 1'b0;
        i_avs_writedata = 32'h0;
        i_avs_byteenable = 4'hf;
        i_event = '0;
        i_event_locked_pw = 1'b0;
        i_secondary_system_error_in_n = 1'b1;
        i_req = '0;
        i_pri_lock_n = 1'b1;
        i_pri_frame_n = 1'b1;
        i_queue_older_empty = 1'b1;
        i_repeat_match = 1'b0;
        i_pw_done_unlock = 1'b0;
        p_mode = 2'h0;
        p_delay = 2'h0;
        p_other = 1'b0;
        n_fail = 0;
        samples_checked = 0;
        repeat (16) @(posedge i_clk);
        i_rstn <= 1'b1;
        chk(o_primary_system_error_out_oe_n, 1'b1);
        chk(o_sec_lock_out_oe_n, 1'b1);
        wr(ADDR_STAT, 32'hc);
        foreach (regs[k]) rdc(regs[k], 32'h0);
        tend("reset");
        ev(7'h1, 1'b0, 1'b0);
        wr(ADDR_CTRL, 32'h1);
        wr(4'h2, 32'hf);
        rdc(ADDR_CTRL, 32'h1);
        // Each cause but the timeout, plain then masked
        for (int k = 0; k < 6; k++) begin
            ev(7'h1 << k, 1'b0, 1'b1);
            rdc(ADDR_EVT, 32'h1 << k);
            rdc(ADDR_STAT, 32'h1 << ST_SIG_SERR);
            wr(ADDR_MASK, 32'h1 << k);
            ev(7'h1 << k, 1'b0, 1'b0);
            wr(ADDR_MASK, 32'h0);
            clr();
        end
        rdc(ADDR_EVT, 32'h0);
        ev(7'h1 << EV_MTO, 1'b0, 1'b0);
        wr(ADDR_CTRL, 32'h5);
        wr(ADDR_MASK, 32'h7f);
        ev(7'h1 << EV_MTO, 1'b0, 1'b1);
        wr(ADDR_MASK, 32'h0);
        wr(ADDR_CTRL, 32'h1);
        ev(7'h1 << EV_MA_PW, 1'b1, 1'b0);
        ev(7'h1 << EV_TA_PW, 1'b1, 1'b1);
        wr(ADDR_CTRL, 32'h9);
        ev(7'h1 << EV_MA_PW, 1'b1, 1'b1);
        clr();
        tend("events");
        // Forwarded secondary error, reporting off first
        wr(ADDR_CTRL, 32'h2);
        i_secondary_system_error_in_n <= 1'b0;
        repeat (2) @(posedge i_clk);
        #1 chk(o_primary_system_error_out_oe_n, 1'b1);
        wr(ADDR_CTRL, 32'h3);
        @(posedge i_clk);
        #1 chk(o_primary_system_error_out_oe_n, 1'b0);
        @(posedge i_clk);
        i_secondary_system_error_in_n <= 1'b1;
        rdc(ADDR_STAT, 32'h3);
        wr(ADDR_CTRL, 32'h0);
        clr();
        tend("forward");
        // Locked read behind older work and foreign lock
        req(1'b1, 1'b0, 1'b1, CMD_MEM_READ);
        chk(o_queue_block, 1'b0);
        rel();
        i_queue_older_empty <= 1'b0;
        p_other <= 1'b1;
        req(1'b1, 1'b1, 1'b1, CMD_MEM_READ);
        chk(rsp_q.retry, 1'b1);
        rel();
        p_other <= 1'b0;
        req(1'b1, 1'b1, 1'b1, CMD_MEM_READ);
        chk(o_queue_block, 1'b1);
        req(1'b0, 1'b1, 1'b0, CMD_MEM_WRITE);
        chk(rsp_q.retry, 1'b1);
        p_other <= 1'b1;
        i_queue_older_empty <= 1'b1;
        repeat (3) @(posedge i_clk);
        #1 chk(o_issue_locked, 1'b0);
        @(posedge i_clk);
        p_other <= 1'b0;
        p_delay <= 2'h2;
        waitlock();
        @(posedge i_clk);
        i_repeat_match <= 1'b1;
        @(posedge i_clk);
        i_repeat_match <= 1'b0;
        #1 chk(o_pri_lock_held, 1'b1);
        req(1'b1, 1'b1, 1'b0, CMD_MEM_READ);
        chk(rsp_q.forward_locked, 1'b1);
        chk(rsp_q.no_prefetch, 1'b1);
        req(1'b1, 1'b1, 1'b1, CMD_MEM_READ);
        chk(rsp_q.retry, 1'b1);
        chk(o_sec_lock_out_oe_n, 1'b0);
        rel();
        chk(o_sec_lock_out_oe_n, 1'b1);
        tend("lock");
        foreach (bad_cmd[k]) begin
            req(1'b1, 1'b1, 1'b1, bad_cmd[k]);
            chk(rsp_q.master_abort, 1'b1);
            rel();
        end
        // Retried first access, then an abort
        p_mode <= 2'h1;
        req(1'b1, 1'b1, 1'b1, CMD_MEM_READ);
        rdc(ADDR_STAT, 32'h0);
        p_mode <= 2'h2;
        repeat (6) @(posedge i_clk);
        rdc(ADDR_STAT, 32'h1 << ST_ABN_TERM);
        req(1'b1, 1'b1, 1'b1, CMD_MEM_READ);
        chk(rsp_q.master_abort, 1'b1);
        rel();
        chk(o_queue_block, 1'b0);
        clr();
        tend("abort");
        // Timeout while locked, then posted final write
        p_mode <= 2'h0;
        wr(ADDR_CTRL, 32'h5);
        req(1'b1, 1'b1, 1'b1, CMD_MEM_READ);
        waitlock();
        ev(7'h1 << EV_MTO, 1'b0, 1'b1);
        chk(o_sec_lock_out_oe_n, 1'b1);
        rdc(ADDR_STAT, 32'h1);
        rel();
        req(1'b1, 1'b1, 1'b1, CMD_MEM_READ);
        waitlock();
        @(posedge i_clk);
        i_repeat_match <= 1'b1;
        @(posedge i_clk);
        i_repeat_match <= 1'b0;
        i_pw_done_unlock <= 1'b1;
        @(posedge i_clk);
        i_pw_done_unlock <= 1'b0;
        #1 chk(o_sec_lock_out_oe_n, 1'b1);
        rel();
        tend("release");
        conclude();
    end

    // Watchdog, far past run length
    initial begin
        repeat (20000) @(posedge i_clk);
        n_fail++;
        conclude();
    end
endmodule

//--- tb/lock_serr_partner.sv
// Secondary bus model: locked read target, lock wire, foreign lock
module lock_serr_partner (
    input wire logic i_clk, // Bus clock
    input wire logic i_rstn, // Bus reset, active low
    input wire logic i_issue, // Locked read launched by the bridge
    input wire logic [1:0] i_mode, // 0 data, 1 retry, 2 abort
    input wire logic [1:0] i_delay, // Wait states before answering
    input wire logic i_other_lock, // Foreign master holds the lock
    input wire logic i_lock_oe_n, // Bridge lock drive, low drives
    output logic o_sec_idle, // No transfer in flight
    output logic o_lock_n, // Resolved lock wire
    output logic o_data_done, // Data phase completed
    output logic o_retry, // Target retry
    output logic o_abort // Target abort
);
    timeunit 1ns;
    timeprecision 1ns;
    logic busy_r;
    logic [1:0] cnt_r;
    // pulled-up lock wire, low while any party drives it
    assign o_lock_n = !(i_other_lock || !i_lock_oe_n);
    assign o_sec_idle = !busy_r;
    // Answer only once the wait states have run out
    assign o_data_done = busy_r && cnt_r == 2'h0 && i_mode == 2'h0;
    assign o_retry = busy_r && cnt_r == 2'h0 && i_mode == 2'h1;
    assign o_abort = busy_r && cnt_r == 2'h0 && i_mode == 2'h2;
    // Transfer tracking; a launch while busy is ignored
    always_ff @(posedge i_clk or negedge i_rstn) begin
        if (!i_rstn) begin
            busy_r <= 1'b0;
            cnt_r <= 2'h0;
        end else if (i_issue && !busy_r) begin
            busy_r <= 1'b1;
            cnt_r <= i_delay;
        end else if (cnt_r != 2'h0) begin
            cnt_r <= cnt_r - 2'h1;
        end else begin
            busy_r <= 1'b0;
        end
    end
endmodule

//--- verilog/lock_serr_ctrl.sv
// Lock forwarding and primary system error reporting for a bridge
//
// Overview of operation
// R01: System error output asserts only with its enable bit set.
// R02: Each system error assertion sets the signaled flag.
// R03: Forwarded secondary error drives output and sets received flag.
// R04: Posted write aborts, parity, retry exhaustion events raise system error.
// R05: Event register records causes; mask bits suppress events.
// R06: Master timeout gated only by its own enable, no mask bit.
// R07: Primary and secondary locks independent unless crossing bridge.
// R08: Initiator checks idle bus and free lock, asserts lock after address.
// R09: Only downstream locks honoured; upstream locks forwarded unlocked.
// R10: Initial locked request retried when a lock exists or target bus locked; not retried in LK_TGT_LOCKED or LK_ABORTED.
// R11: First locked access not memory read ends with master abort.
// R12: Locked sequence still posts writes and never prefetches reads.
// R13: Queued locked read blocks queueing; older work finishes first.
// R14: Locked read issued at queue head, waits for foreign lock release.
// R15: Target lock on first data; initiator lock on matching repeat read.
// R16: Master timeout raises error, discards data, releases target lock.
// R17: After target lock, forwarded locked accesses drive target lock.
// R18: Target retry releases lock only on first transaction of sequence.
// R19: Delayed final access: release target lock after lock and frame idle.
// R20: Posted final write releases target lock at end of the write.
// R21: Aborted locked delayed access returns abort, no lock, sets status.
// R22: Locked posted write abort raises error; master abort needs abort mode.
// R23: Reset clears lock and error event state.
//
// Added by the designer: the address map and the Avalon-MM slave port.
module lock_serr_ctrl
    import lock_serr_pkg::*;
(
    input wire logic i_clk,                  // 20 MHz clock
    input wire logic i_rstn,                 // Async reset, active low
    // Avalon-MM slave
    input wire logic [3:0] i_avs_address,    // Byte address
    input wire logic i_avs_read,             // Read strobe
    input wire logic i_avs_write,            // Write strobe
    input wire logic [31:0] i_avs_writedata, // Write data
    input wire logic [3:0] i_avs_byteenable, // Byte lanes
    output logic [31:0] o_avs_readdata,      // Read data, registered
    output logic o_avs_waitrequest,          // Wait, combinational
    // Error events from the bridge queues, one-cycle pulses
    input wire logic [NUM_EV-1:0] i_event,   // Error causes
    input wire logic i_event_locked_pw,      // Event belongs to locked posted write
    input wire logic i_secondary_system_error_in_n, // Secondary error, active low
    output logic o_primary_system_error_out_oe_n,   // Open-drain enable, low drives
    // Primary locked request and answer
    input wire lock_req_t i_req,             // Decoded primary access
    output lock_rsp_t o_rsp,                 // Registered answer
    input wire logic i_pri_lock_n,           // Primary lock pin, active low
    input wire logic i_pri_frame_n,          // Primary frame, active low
    // Secondary side
    input wire logic i_queue_older_empty,    // Older queued work done
    input wire logic i_sec_idle,             // Secondary bus idle
    input wire logic i_sec_lock_in_n,        // Secondary lock pin, active low
    input wire logic i_sec_data_done,        // Locked read data phase done
    input wire logic i_sec_retry,            // Target retry on locked access
    input wire logic i_sec_abort,            // Target or master abort
    input wire logic i_repeat_match,         // Repeat read matches, data returned
    input wire logic i_pw_done_unlock,       // Final locked posted write ended
    output logic o_queue_block,              // Refuse new queue entries
    output logic o_issue_locked,             // Start locked read on secondary
    output logic o_sec_lock_out_oe_n,        // Secondary lock drive enable, low drives
    output logic o_pri_lock_held             // Primary initiator lock established
);
    logic [31:0] ctrl_r;
    logic [NUM_EV-1:0] mask_r;
    logic [NUM_EV-1:0] evt_r;
    logic sig_serr_r;
    logic rcv_serr_r;
    logic abn_term_r;
    logic serr_r;
    logic rd_pend_r;
    logic lock_in_prev_r;
    lock_state_t state_r;
    logic [NUM_EV-1:0] ev_gate;
    logic serr_cause;
    logic sec_serr;
    logic acc;
    logic tgt_locked;
    logic stat_wr;

    assign acc = i_avs_read | i_avs_write;
    assign sec_serr = ~i_secondary_system_error_in_n;
    assign stat_wr = i_avs_write && i_avs_address == ADDR_STAT && i_avs_byteenable[0];

    // Writes take no wait; reads wait one cycle for registered data
    assign o_avs_waitrequest = i_avs_read & ~rd_pend_r;

    // Bus write decode for control and mask
    always_ff @(posedge i_clk or negedge i_rstn) begin
        if (!i_rstn) begin
            ctrl_r <= RESET_WORD;
            mask_r <= '0;
        end else if (i_avs_write) begin
            if (i_avs_address == ADDR_CTRL && i_avs_byteenable[0]) begin
                ctrl_r[7:0] <= i_avs_writedata[7:0];
            end
            if (i_avs_address == ADDR_MASK && i_avs_byteenable[0]) begin
                mask_r <= i_avs_writedata[NUM_EV-1:0];
            end
        end
    end

    // Read data, one cycle after the strobe
    always_ff @(posedge i_clk or negedge i_rstn) begin
        if (!i_rstn) begin
            rd_pend_r <= 1'b0;
            o_avs_readdata <= RESET_WORD;
        end else begin
            rd_pend_r <= i_avs_read & ~rd_pend_r;
            if (i_avs_read & ~rd_pend_r) begin
                case (i_avs_address)
                    ADDR_CTRL: o_avs_readdata <= {24'h000000, ctrl_r[7:0]};
                    ADDR_MASK: o_avs_readdata <= {{(32-NUM_EV){1'b0}}, mask_r};
                    ADDR_EVT: o_avs_readdata <= {{(32-NUM_EV){1'b0}}, evt_r};
                    ADDR_STAT: o_avs_readdata <= {27'h0000000, abn_term_r,
                        o_pri_lock_held, tgt_locked, rcv_serr_r, sig_serr_r};
                    default: o_avs_readdata <= UNMAPPED_WORD;
                endcase
            end
        end
    end

    // Gating: locked posted write master abort needs abort mode, timeout its own enable
    always_comb begin
        ev_gate = i_event & ~mask_r;
        // R22: abort mode gating
        if (!ctrl_r[CTRL_MA_MODE] && i_event_locked_pw) begin
            ev_gate[EV_MA_PW] = 1'b0;
        end
        // R06: timeout enable only
        ev_gate[EV_MTO] = i_event[EV_MTO] & ctrl_r[CTRL_MTO_EN];
    end

    // R04: causes, forwarded secondary error included
    assign serr_cause = (|ev_gate) | (sec_serr & ctrl_r[CTRL_FWD_EN]);

    // R01: output needs the enable bit
    always_ff @(posedge i_clk or negedge i_rstn) begin
        if (!i_rstn) begin
            serr_r <= 1'b0;
        end else begin
            serr_r <= serr_cause & ctrl_r[CTRL_SERR_EN];
        end
    end
    assign o_primary_system_error_out_oe_n = ~serr_r;

    // R05: sticky event record, set wins over write-one clear
    always_ff @(posedge i_clk or negedge i_rstn) begin
        if (!i_rstn) begin
            evt_r <= '0;
        end else begin
            for (int i = 0; i < NUM_EV; i++) begin
                if (ev_gate[i] && ctrl_r[CTRL_SERR_EN]) begin
                    evt_r[i] <= 1'b1;
                end else if (i_avs_write && i_avs_address == ADDR_EVT &&
                             i_avs_byteenable[0] && i_avs_writedata[i]) begin
                    evt_r[i] <= 1'b0;
                end
            end
        end
    end

    // R02: signaled flag; R03: received flag; both write-one clear
    always_ff @(posedge i_clk or negedge i_rstn) begin
        if (!i_rstn) begin
            sig_serr_r <= 1'b0;
            rcv_serr_r <= 1'b0;
            abn_term_r <= 1'b0;
        end else begin
            if (serr_r) begin
                sig_serr_r <= 1'b1;
            end else if (stat_wr && i_avs_writedata[ST_SIG_SERR]) begin
                sig_serr_r <= 1'b0;
            end
            if (sec_serr && ctrl_r[CTRL_FWD_EN]) begin
                rcv_serr_r <= 1'b1;
            end else if (stat_wr && i_avs_writedata[ST_RCV_SERR]) begin
                rcv_serr_r <= 1'b0;
            end
            // R21: abnormal termination status
            if (state_r == LK_WAIT_BUS && i_sec_abort) begin
                abn_term_r <= 1'b1;
            end else if (stat_wr && i_avs_writedata[ST_ABN_TERM]) begin
                abn_term_r <= 1'b0;
            end
        end
    end

    // Previous primary lock level, for release detection
    always_ff @(posedge i_clk or negedge i_rstn) begin
        if (!i_rstn) begin
            lock_in_prev_r <= 1'b0;
        end else begin
            lock_in_prev_r <= ~i_pri_lock_n;
        end
    end

    // R07: only crossing sequences reach here; local locks untouched
    // R23: reset to unlocked
    always_ff @(posedge i_clk or negedge i_rstn) begin
        if (!i_rstn) begin
            state_r <= LK_IDLE;
        end else begin
            case (state_r)
                // R09: upstream locked requests ignored here
                LK_IDLE: begin
                    if (i_req.valid && i_req.locked && i_req.downstream && i_req.first &&
                        i_req.cmd == CMD_MEM_READ && i_sec_lock_in_n) begin
                        state_r <= LK_QUEUED;
                    end
                end
                // R14: wait for queue head, idle free target bus
                LK_QUEUED: begin
                    if (i_queue_older_empty && i_sec_idle && i_sec_lock_in_n) begin
                        state_r <= LK_WAIT_BUS;
                    end
                end
                LK_WAIT_BUS: begin
                    // R21: abort gives no lock
                    if (i_sec_abort) begin
                        state_r <= LK_ABORTED;
                    // R18: retry on first access drops the attempt
                    end else if (i_sec_retry) begin
                        state_r <= LK_QUEUED;
                    // R15: target lock on first data
                    end else if (i_sec_data_done) begin
                        state_r <= LK_TGT_LOCKED;
                    end
                end
                LK_TGT_LOCKED: begin
                    // R16: timeout discards and releases
                    if (i_event[EV_MTO]) begin
                        state_r <= LK_IDLE;
                    // R15: initiator lock on matching repeat
                    end else if (i_repeat_match) begin
                        state_r <= LK_BOTH_LOCKED;
                    end
                end
                LK_BOTH_LOCKED: begin
                    // R19: release after lock and frame idle; R20: posted write end
                    if ((i_pri_lock_n && i_pri_frame_n && !lock_in_prev_r) ||
                        i_pw_done_unlock) begin
                        state_r <= LK_IDLE;
                    end
                end
                // Abort returned to repeats until the initiator drops its lock
                LK_ABORTED: begin
                    if (i_pri_lock_n && i_pri_frame_n) begin
                        state_r <= LK_IDLE;
                    end
                end
                default: state_r <= LK_IDLE;
            endcase
        end
    end

    assign tgt_locked = state_r == LK_TGT_LOCKED || state_r == LK_BOTH_LOCKED;
    assign o_pri_lock_held = state_r == LK_BOTH_LOCKED;
    // R13: block queueing while locked read pending or held
    assign o_queue_block = state_r != LK_IDLE;
    // R14: issue; lock drive follows address
    assign o_issue_locked = state_r == LK_QUEUED && i_queue_older_empty &&
        i_sec_idle && i_sec_lock_in_n;
    // R17: hold target lock while sequence lives
    assign o_sec_lock_out_oe_n = ~(tgt_locked ||
        (state_r == LK_WAIT_BUS && !i_sec_idle));

    // Answers to primary accesses, registered
    always_ff @(posedge i_clk or negedge i_rstn) begin
        if (!i_rstn) begin
            o_rsp <= '0;
        end else begin
            o_rsp <= '0;
            if (i_req.valid && i_req.downstream) begin
                // R10: retry when lock exists or target locked by another, except in LK_TGT_LOCKED and LK_ABORTED
                if (i_req.locked && i_req.first && (state_r != LK_IDLE || !i_sec_lock_in_n)) begin
                    o_rsp.retry <= (state_r != LK_TGT_LOCKED && state_r != LK_ABORTED);
                // R11: non-read first locked access aborts
                end else if (i_req.locked && i_req.first && i_req.cmd != CMD_MEM_READ) begin
                    o_rsp.master_abort <= 1'b1;
                // R13: retry cross-bridge traffic during a sequence
                end else if (!i_req.locked && state_r != LK_IDLE) begin
                    o_rsp.retry <= 1'b1;
                end
                // R21: repeat gets the abort
                if (state_r == LK_ABORTED && i_req.locked) begin
                    o_rsp.master_abort <= 1'b1;
                end
                // R12: no prefetch on locked reads; R17: forward locked
                o_rsp.no_prefetch <= i_req.locked;
                o_rsp.forward_locked <= i_req.locked && state_r == LK_BOTH_LOCKED;
            end
        end
    end

    // R01: output never without enable
    chk_serr_enable: assert property (@(posedge i_clk) disable iff (!i_rstn) // R01
        !o_primary_system_error_out_oe_n |-> $past(ctrl_r[CTRL_SERR_EN]))
        else $error("system error driven while disabled");
    // R02: signaled flag follows output
    chk_sig_flag: assert property (@(posedge i_clk) disable iff (!i_rstn) // R02
        !o_primary_system_error_out_oe_n |=> sig_serr_r)
        else $error("signaled flag not set");
    // R03: forwarded error drives output
    chk_fwd_serr: assert property (@(posedge i_clk) disable iff (!i_rstn) // R03
        sec_serr && ctrl_r[CTRL_FWD_EN] && ctrl_r[CTRL_SERR_EN]
        |=> !o_primary_system_error_out_oe_n && rcv_serr_r)
        else $error("secondary error not forwarded");
    // R05: masked event not recorded
    chk_mask_event: assert property (@(posedge i_clk) disable iff (!i_rstn) // R05
        i_event[EV_TA_PW] && mask_r[EV_TA_PW] && !evt_r[EV_TA_PW] && !i_avs_write
        |=> !evt_r[EV_TA_PW])
        else $error("masked event recorded");
    // R06: timeout needs its enable
    chk_mto_gate: assert property (@(posedge i_clk) disable iff (!i_rstn) // R06
        i_event[EV_MTO] && !ctrl_r[CTRL_MTO_EN] |-> !ev_gate[EV_MTO])
        else $error("timeout passed without enable");
    // R11: first I/O locked access aborts
    chk_first_read: assert property (@(posedge i_clk) disable iff (!i_rstn) // R11
        i_req.valid && i_req.downstream && i_req.locked && i_req.first &&
        i_req.cmd == CMD_IO && state_r == LK_IDLE && i_sec_lock_in_n
        |=> o_rsp.master_abort)
        else $error("non-read locked start not aborted");
    // R13: queue blocked in sequence
    chk_queue_block: assert property (@(posedge i_clk) disable iff (!i_rstn) // R13
        $rose(state_r == LK_QUEUED) |-> o_queue_block)
        else $error("queue not blocked");
    // R16: timeout releases target lock
    chk_mto_release: assert property (@(posedge i_clk) disable iff (!i_rstn) // R16
        state_r == LK_TGT_LOCKED && i_event[EV_MTO] |=> o_sec_lock_out_oe_n)
        else $error("lock kept after timeout");
    // R20: posted write end releases lock
    chk_pw_release: assert property (@(posedge i_clk) disable iff (!i_rstn) // R20
        state_r == LK_BOTH_LOCKED && i_pw_done_unlock |=> state_r == LK_IDLE)
        else $error("lock kept after posted write");
endmodule

//--- verilog/lock_serr_pkg.sv
// Register map, fields and types for lock and system error control
package lock_serr_pkg;
    // Register word byte addresses
    localparam logic [3:0] ADDR_CTRL = 4'h0;
    localparam logic [3:0] ADDR_MASK = 4'h4;
    localparam logic [3:0] ADDR_EVT = 4'h8;
    localparam logic [3:0] ADDR_STAT = 4'hc;
    // Control register bit positions
    localparam int CTRL_SERR_EN = 0;
    localparam int CTRL_FWD_EN = 1;
    localparam int CTRL_MTO_EN = 2;
    localparam int CTRL_MA_MODE = 3;
    // Event bit positions
    localparam int EV_TA_PW = 0;
    localparam int EV_MA_PW = 1;
    localparam int EV_RTY_PW = 2;
    localparam int EV_PERR_PW = 3;
    localparam int EV_RTY_DW = 4;
    localparam int EV_RTY_DR = 5;
    localparam int EV_MTO = 6;
    localparam int NUM_EV = 7;
    // Status register bit positions
    localparam int ST_SIG_SERR = 0;
    localparam int ST_RCV_SERR = 1;
    localparam int ST_LOCK_TGT = 2;
    localparam int ST_LOCK_INI = 3;
    localparam int ST_ABN_TERM = 4;
    localparam logic [31:0] RESET_WORD = 32'h0000_0000;
    localparam logic [31:0] UNMAPPED_WORD = 32'h0000_0000;
    // Log2 of the default target retry count before data is abandoned
    localparam int RETRY_LIMIT_LOG2 = 24;

    // Transaction command class seen at the primary target
    typedef enum logic [2:0] {
        CMD_MEM_READ,
        CMD_MEM_WRITE,
        CMD_IO,
        CMD_CFG0,
        CMD_CFG1,
        CMD_OTHER
    } cmd_t;

    // Primary-side locked request from the target decoder
    typedef struct packed {
        logic valid;    // One-cycle request
        logic locked;   // Lock sampled per locked sequence
        logic downstream; // Target on secondary side
        logic first;    // Initial access of a sequence
        cmd_t cmd;
    } lock_req_t;

    // Answer to the primary target
    typedef struct packed {
        logic retry;
        logic master_abort;
        logic forward_locked;
        logic no_prefetch;
    } lock_rsp_t;

    // Lock sequence state
    typedef enum logic [2:0] {
        LK_IDLE,
        LK_QUEUED,
        LK_WAIT_BUS,
        LK_TGT_LOCKED,
        LK_BOTH_LOCKED,
        LK_ABORTED
    } lock_state_t;
endpackage
